// File: dv/dos_mib_master.sv
// Register bus master model standing in for the management side
`timescale 1ns/1ps
module dos_mib_master
  import dos_pkg::*;
(
  input  wire logic                  aclk,
  output logic                       awvalid,
  input  wire logic                  awready,
  output logic      [DOS_ADDR_W-1:0] awaddr,
  output logic                       wvalid,
  input  wire logic                  wready,
  output logic      [31:0]           wdata,
  output logic      [3:0]            wstrb,
  input  wire logic                  bvalid,
  output logic                       bready,
  input  wire logic [1:0]            bresp,
  output logic                       arvalid,
  input  wire logic                  arready,
  output logic      [DOS_ADDR_W-1:0] araddr,
  input  wire logic                  rvalid,
  output logic                       rready,
  input  wire logic [31:0]           rdata,
  input  wire logic [1:0]            rresp
);
  initial begin
    awvalid = 1'b0;
    awaddr  = '0;
    wvalid  = 1'b0;
    wdata   = '0;
    wstrb   = '0;
    bready  = 1'b0;
    arvalid = 1'b0;
    araddr  = '0;
    rready  = 1'b0;
  end

  // ---------------------------------------------------------------
  // Configuration words
  // ---------------------------------------------------------------
  // Splits go out as whole percentages; no-limit flags travel beside them
  function automatic logic [31:0] split_word(input logic [7:0] f, input logic [7:0] e,
                                             input logic [1:0] nl);
    return {14'h0000, nl, e, f};
  endfunction : split_word

  // ---------------------------------------------------------------
  // Bus cycles
  // ---------------------------------------------------------------
  // Released payload is inverted so a stale value can never look valid
  task automatic axi_write(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    wstrb   <= 4'hF;
    bready  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
        awaddr  <= ~a;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
        wdata  <= ~d;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    araddr  <= ~a;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_read
endmodule : dos_mib_master

// File: dv/tb_top.sv
// Self-checking bench for the delay octet split calculator
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_top
  import dos_pkg::*;
;
  logic                  aclk;
  logic                  aresetn;
  logic                  awvalid, awready, wvalid, wready, bvalid, bready;
  logic                  arvalid, arready, rvalid, rready;
  logic [DOS_ADDR_W-1:0] awaddr, araddr;
  logic [31:0]           wdata, rdata, rd;
  logic [3:0]            wstrb;
  logic [1:0]            bresp, rresp, rsp;
  int                    n_mismatch, check_count, cycles;
  int                    bt[6] = '{1000, 1001, 999, 999, 7, 65535};
  int                    fp[6] = '{50, 33, 5, 95, 10, 95};
  int                    ep[6] = '{95, 5, 50, 33, 90, 5};
  int                    ds, es;

  dos_delay_octet_split DUT (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
    .rdata, .rresp);
  dos_mib_master mst (.aclk, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);

  initial aclk = 1'b0;
  always #5 aclk = ~aclk;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic int ceil_pct(input int p, input int b);
    return (p * b + 99) / 100;
  endfunction : ceil_pct

  function automatic logic [31:0] pk(input int hi, input int lo);
    return {hi[15:0], lo[15:0]};
  endfunction : pk

  task automatic conclude();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    mst.axi_write(a, d, rsp);
    `CHK(rsp, DOS_RESP_OKAY)
  endtask : wr

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
    mst.axi_read(a, rd, rsp);
    `CHK(rd, e)
  endtask : rd_chk

  // Status is polled a bounded number of times; the result lands one cycle after start
  task automatic run(input int b, input logic [31:0] s, input logic [2:0] c);
    int n;
    wr(DOS_OFS_BUDGET, pk(0, b));
    wr(DOS_OFS_SPLIT, s);
    wr(DOS_OFS_CTRL, 32'(c) | 32'h0000_0001);
    n = 0;
    rd = 32'h0000_0000;
    while (rd[1] !== 1'b1 && n < 8) begin
      mst.axi_read(DOS_OFS_STATUS, rd, rsp);
      n++;
    end
    `CHK(rd[1:0], 2'b10)
  endtask : run

  // One exception step at a budget of 200: status, framing and estimate results
  task automatic step(input logic [31:0] s, input int st, input logic [31:0] f,
                      input logic [31:0] e);
    run(200, s, 3'b000);
    `CHK(rd, pk(0, st))
    rd_chk(DOS_OFS_FRM, f);
    rd_chk(DOS_OFS_EST, e);
  endtask : step

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      conclude();
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    aresetn = 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(DOS_OFS_CTRL, 32'h0000_0000);
    rd_chk(DOS_OFS_BUDGET, 32'h0000_0000);
    rd_chk(DOS_OFS_SPLIT, 32'h0000_3232);
    rd_chk(DOS_OFS_RATIO, 32'h0000_0032);
    rd_chk(DOS_OFS_STATUS, 32'h0000_0000);
    rd_chk(DOS_OFS_FRM, 32'h0000_0000);
    // Unmapped and misaligned places answer with a decode error
    mst.axi_read(6'h30, rd, rsp);
    `CHK(rsp, DOS_RESP_DECERR)
    `CHK(rd, 32'h0000_0000)
    mst.axi_read(6'h06, rd, rsp);
    `CHK(rsp, DOS_RESP_DECERR)
    mst.axi_write(6'h30, 32'h0000_FFFF, rsp);
    `CHK(rsp, DOS_RESP_DECERR)
    // Fractional shares round up, upstream takes the remainder, single latency path 0
    for (int i = 0; i < 6; i++) begin
      run(bt[i], mst.split_word(fp[i][7:0], ep[i][7:0], 2'b00), 3'b000);
      `CHK(rd, 32'h0000_0002)
      ds = ceil_pct(fp[i], bt[i]);
      es = ceil_pct(ep[i], bt[i]);
      rd_chk(DOS_OFS_FRM, pk(bt[i] - ds, ds));
      rd_chk(DOS_OFS_FRM_DS, pk(0, ds));
      rd_chk(DOS_OFS_FRM_US, pk(0, bt[i] - ds));
      rd_chk(DOS_OFS_EST, pk(bt[i] - es, es));
      rd_chk(DOS_OFS_EST_DS, pk(0, es));
      rd_chk(DOS_OFS_EST_US, pk(0, bt[i] - es));
    end
    // Boundary splits pass only with their no-limit flag; refused splits keep the previous results
    step(mst.split_word(8'h28, 8'h3C, 2'b00), 2, pk(120, 80), pk(80, 120));
    step(mst.split_word(8'h00, 8'h3C, 2'b00), 6, pk(120, 80), pk(80, 120));
    step(mst.split_word(8'h00, 8'h3C, 2'b01), 2, pk(200, 0), pk(80, 120));
    step(mst.split_word(8'h64, 8'h65, 2'b01), 14, pk(200, 0), pk(80, 120));
    step(mst.split_word(8'h64, 8'h3C, 2'b10), 2, pk(0, 200), pk(80, 120));
    step(mst.split_word(8'h04, 8'h3C, 2'b00), 6, pk(0, 200), pk(80, 120));
    step(mst.split_word(8'h60, 8'h00, 2'b00), 14, pk(0, 200), pk(80, 120));
    step(mst.split_word(8'hFF, 8'hFF, 2'b00), 50, pk(100, 100), pk(100, 100));
    step(mst.split_word(8'h5F, 8'h05, 2'b00), 2, pk(10, 190), pk(190, 10));
    // Dual latency divides each framing direction share by the rate adaptation ratio; estimates stay whole
    wr(DOS_OFS_RATIO, 32'h0000_0019);
    run(999, mst.split_word(8'h21, 8'h32, 2'b00), 3'b010);
    rd_chk(DOS_OFS_FRM, pk(669, 330));
    rd_chk(DOS_OFS_FRM_DS, pk(330 - ceil_pct(25, 330), ceil_pct(25, 330)));
    rd_chk(DOS_OFS_FRM_US, pk(669 - ceil_pct(25, 669), ceil_pct(25, 669)));
    rd_chk(DOS_OFS_EST_DS, pk(0, 500));
    // Robust overhead path subtracts the path 0 octets in force at each start
    wr(DOS_OFS_PATH0, pk(50, 120));
    run(1000, mst.split_word(8'h32, 8'h1E, 2'b00), 3'b100);
    rd_chk(DOS_OFS_EST_DS, pk(180, 120));
    rd_chk(DOS_OFS_EST_US, pk(650, 50));
    wr(DOS_OFS_PATH0, pk(700, 10));
    run(1000, mst.split_word(8'h32, 8'h1E, 2'b00), 3'b100);
    rd_chk(DOS_OFS_EST_DS, pk(290, 10));
    rd_chk(DOS_OFS_EST_US, pk(0, 700));
    conclude();
  end
endmodule : tb_top

// File: logic/dos_delay_octet_split.sv
// Delay octet split calculator with AXI4-Lite register access
//
// What this block does
// (RQ1) Downstream share is split of budget, rounded up
// (RQ2) Upstream gets the budget minus downstream share
// (RQ3) Each direction share covers all latency paths
// (RQ4) Path 0 plus path 1 limit within direction share
// (RQ5) Never move octets between directions for line conditions
// (RQ6) Dual latency divides share by rate adaptation ratio
// (RQ7) Framing split is whole percent 5 to 95
// (RQ8) 0%/100% valid only with no-limit delay
// (RQ9) Special split value allows own path algorithm
// (RQ10) Second split gives rate estimate budgets likewise
// (RQ11) Single latency estimate: path 0 equals budget
// (RQ12) Robust path estimate: path 1 is budget minus path 0
// (RQ13) Path 0 octets are those in force at compute
// (RQ14) Estimate split has same range and exceptions
// (RQ15) Integer ceiling arithmetic, flag split values not permitted
`timescale 1ns/1ps
module dos_delay_octet_split
  import dos_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [DOS_ADDR_W-1:0] awaddr,
  input  wire logic                  wvalid,
  output logic                       wready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  output logic                       bvalid,
  input  wire logic                  bready,
  output logic      [1:0]            bresp,
  input  wire logic                  arvalid,
  output logic                       arready,
  input  wire logic [DOS_ADDR_W-1:0] araddr,
  output logic                       rvalid,
  input  wire logic                  rready,
  output logic      [31:0]           rdata,
  output logic      [1:0]            rresp
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    dos_state_t            st;
    dos_cfg_t              cfg;
    dos_cfg_t              snap;
    dos_pair_t             frm;
    dos_pair_t             frm_ds;
    dos_pair_t             frm_us;
    dos_pair_t             est;
    dos_pair_t             est_ds;
    dos_pair_t             est_us;
    logic                  done;
    logic                  frm_bad;
    logic                  est_bad;
    logic                  frm_spec;
    logic                  est_spec;
    logic                  aw_got;
    logic [DOS_ADDR_W-1:0] aw_addr;
    logic                  w_got;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
  } dos_regs_t;

  dos_regs_t q;
  dos_regs_t d;

  // ---------------------------------------------------------------
  // Arithmetic on the snapshot taken at start
  // ---------------------------------------------------------------
  logic [15:0] frm_ds_sh;
  logic [15:0] frm_us_sh;
  logic        frm_ok;
  logic        frm_sp;
  logic [15:0] est_ds_sh;
  logic [15:0] est_us_sh;
  logic        est_ok;
  logic        est_sp;
  logic [7:0]  path_pct;
  logic [15:0] ds_p0;
  logic [15:0] ds_p1;
  logic [15:0] us_p0;
  logic [15:0] us_p1;
  logic [15:0] ds_used;
  logic [15:0] us_used;

  dos_split_calc #(.W(16)) u_frm (
    .pct     (q.snap.frm_pct),
    .budget  (q.snap.budget),
    .nl_ds   (q.snap.nl_ds),
    .nl_us   (q.snap.nl_us),
    .share   (frm_ds_sh),
    .rest    (frm_us_sh),
    .ok      (frm_ok),
    .special (frm_sp)
  );

  dos_split_calc #(.W(16)) u_est ( // see RQ10
    .pct     (q.snap.est_pct),
    .budget  (q.snap.budget),
    .nl_ds   (q.snap.nl_ds),
    .nl_us   (q.snap.nl_us),
    .share   (est_ds_sh),
    .rest    (est_us_sh),
    .ok      (est_ok),
    .special (est_sp)
  );

  // Single latency puts the whole share on path 0; dual latency splits it
  // by the rate adaptation ratio so the pair never exceeds the share
  assign path_pct = (q.snap.dual && (q.snap.ratio < DOS_PCT_FULL)) ? q.snap.ratio
                                                                   : DOS_PCT_FULL; // see RQ6

  dos_split_calc #(.W(16)) u_dsp ( // see RQ4
    .pct     (path_pct),
    .budget  (frm_ds_sh),
    .nl_ds   (1'b0),
    .nl_us   (1'b0),
    .share   (ds_p0),
    .rest    (ds_p1),
    .ok      (),
    .special ()
  );

  dos_split_calc #(.W(16)) u_usp ( // see RQ4
    .pct     (path_pct),
    .budget  (frm_us_sh),
    .nl_ds   (1'b0),
    .nl_us   (1'b0),
    .share   (us_p0),
    .rest    (us_p1),
    .ok      (),
    .special ()
  );

  // Path 0 octets in force, capped so the remainder cannot wrap  see RQ13
  assign ds_used = (q.snap.path0.lo > est_ds_sh) ? est_ds_sh : q.snap.path0.lo;
  assign us_used = (q.snap.path0.hi > est_us_sh) ? est_us_sh : q.snap.path0.hi;

  // ---------------------------------------------------------------
  // Register access helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [31:0] rd_word(input dos_regs_t s, input logic [DOS_ADDR_W-1:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      DOS_OFS_CTRL: begin
        r[DOS_CTRL_DUAL] = s.cfg.dual;
        r[DOS_CTRL_ROBUST] = s.cfg.robust;
      end
      DOS_OFS_BUDGET: r[15:0] = s.cfg.budget;
      DOS_OFS_SPLIT: begin
        r[DOS_SPLIT_FRM +: 8] = s.cfg.frm_pct;
        r[DOS_SPLIT_EST +: 8] = s.cfg.est_pct;
        r[DOS_SPLIT_NLDS]     = s.cfg.nl_ds;
        r[DOS_SPLIT_NLUS]     = s.cfg.nl_us;
      end
      DOS_OFS_RATIO:  r[7:0] = s.cfg.ratio;
      DOS_OFS_PATH0:  r = s.cfg.path0;
      DOS_OFS_STATUS: r[5:0] = {s.est_spec, s.frm_spec, s.est_bad, s.frm_bad, s.done,
                                (s.st == DOS_CALC)};
      DOS_OFS_FRM:    r = s.frm;
      DOS_OFS_FRM_DS: r = s.frm_ds;
      DOS_OFS_FRM_US: r = s.frm_us;
      DOS_OFS_EST:    r = s.est;
      DOS_OFS_EST_DS: r = s.est_ds;
      DOS_OFS_EST_US: r = s.est_us;
      default:        r = 32'h0000_0000;
    endcase
    return r;
  endfunction : rd_word

  function automatic logic mapped(input logic [DOS_ADDR_W-1:0] a);
    return (a[1:0] == 2'b00) && (a <= DOS_OFS_EST_US);
  endfunction : mapped

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [31:0] wv;
    wv = 32'h0000_0000;
    d  = q;

    // Address and data are taken in either order and held until paired
    if (awvalid && !q.aw_got) begin
      d.aw_got  = 1'b1;
      d.aw_addr = awaddr;
    end
    if (wvalid && !q.w_got) begin
      d.w_got  = 1'b1;
      d.w_data = wdata;
      d.w_strb = wstrb;
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end

    if (q.aw_got && q.w_got && !q.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = mapped(q.aw_addr) ? DOS_RESP_OKAY : DOS_RESP_DECERR;
      wv = merge(rd_word(q, q.aw_addr), q.w_data, q.w_strb);
      case (q.aw_addr)
        DOS_OFS_CTRL: begin
          d.cfg.dual = wv[DOS_CTRL_DUAL];
          d.cfg.robust = wv[DOS_CTRL_ROBUST];
          // Start is ignored while a calculation is running
          if (q.w_strb[0] && q.w_data[DOS_CTRL_START] && (q.st == DOS_IDLE)) begin
            d.snap      = d.cfg;
            d.st        = DOS_CALC;
            d.done      = 1'b0;
          end
        end
        DOS_OFS_BUDGET: d.cfg.budget = wv[15:0];
        DOS_OFS_SPLIT: begin
          d.cfg.frm_pct = wv[DOS_SPLIT_FRM +: 8];
          d.cfg.est_pct = wv[DOS_SPLIT_EST +: 8];
          d.cfg.nl_ds   = wv[DOS_SPLIT_NLDS];
          d.cfg.nl_us   = wv[DOS_SPLIT_NLUS];
        end
        DOS_OFS_RATIO:  d.cfg.ratio = wv[7:0];
        DOS_OFS_PATH0:  d.cfg.path0 = wv;
        default: ;
      endcase
    end

    // Results change only on a calculation from the configured split,
    // never from anything seen on the line  see RQ5
    case (q.st)
      DOS_CALC: begin
        d.st       = DOS_IDLE;
        d.done     = 1'b1;
        d.frm_bad  = !frm_ok; // see RQ7 see RQ15
        d.est_bad  = !est_ok; // see RQ14 see RQ15
        d.frm_spec = frm_sp;
        d.est_spec = est_sp;
        // A rejected split keeps the last good allocation in place
        if (frm_ok) begin
          d.frm    = '{hi: frm_us_sh, lo: frm_ds_sh}; // see RQ1 see RQ2 see RQ3
          d.frm_ds = '{hi: ds_p1, lo: ds_p0};         // see RQ4
          d.frm_us = '{hi: us_p1, lo: us_p0};         // see RQ4
        end
        if (est_ok) begin
          d.est = '{hi: est_us_sh, lo: est_ds_sh}; // see RQ10
          if (q.snap.robust) begin
            d.est_ds = '{hi: est_ds_sh - ds_used, lo: ds_used}; // see RQ12 see RQ13
            d.est_us = '{hi: est_us_sh - us_used, lo: us_used}; // see RQ12 see RQ13
          end else begin
            d.est_ds = '{hi: 16'h0000, lo: est_ds_sh}; // see RQ11
            d.est_us = '{hi: 16'h0000, lo: est_us_sh}; // see RQ11
          end
        end
      end
      DOS_IDLE: ;
      default: d.st = DOS_IDLE;
    endcase

    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
    if (arvalid && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rdata  = rd_word(q, araddr);
      d.rresp  = mapped(araddr) ? DOS_RESP_OKAY : DOS_RESP_DECERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q             <= '0;
      q.st          <= DOS_IDLE;
      q.cfg.budget  <= DOS_BUDGET_RST;
      q.cfg.frm_pct <= DOS_PCT_RST;
      q.cfg.est_pct <= DOS_PCT_RST;
      q.cfg.ratio   <= DOS_PCT_RST;
    end else begin
      q <= d;
    end
  end

  assign awready = !q.aw_got;
  assign wready  = !q.w_got;
  assign bvalid  = q.bvalid;
  assign bresp   = q.bresp;
  assign arready = !q.rvalid;
  assign rvalid  = q.rvalid;
  assign rdata   = q.rdata;
  assign rresp   = q.rresp;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_DS_CEIL: assert property ((q.st == DOS_CALC) && frm_ok && !frm_sp |=> // see RQ1
    (32'(q.frm.lo) * 32'(DOS_PCT_FULL) >= 32'(q.snap.frm_pct) * 32'(q.snap.budget)) &&
    (32'(q.frm.lo) * 32'(DOS_PCT_FULL) < 32'(q.snap.frm_pct) * 32'(q.snap.budget)
                                          + 32'(DOS_PCT_FULL)))
    else $error("downstream share is not the rounded-up split");

  AST_US_REST: assert property ((q.st == DOS_CALC) && frm_ok |=> // see RQ2
    (32'(q.frm.lo) + 32'(q.frm.hi) == 32'(q.snap.budget)))
    else $error("shares do not add up to the budget");

  AST_PATH_SUM: assert property ((q.st == DOS_CALC) && frm_ok |=> // see RQ4
    (32'(q.frm_ds.lo) + 32'(q.frm_ds.hi) <= 32'(q.frm.lo)) &&
    (32'(q.frm_us.lo) + 32'(q.frm_us.hi) <= 32'(q.frm.hi)))
    else $error("path limits exceed direction share");

  AST_NO_SHIFT: assert property ((q.st == DOS_IDLE) |=> $stable(q.frm) && $stable(q.est)) // see RQ5
    else $error("allocation changed without a calculation");

  AST_DUAL: assert property ((q.st == DOS_CALC) && frm_ok && q.snap.dual |=> // see RQ6
    (32'(q.frm_ds.lo) + 32'(q.frm_ds.hi) == 32'(q.frm.lo)))
    else $error("dual latency split loses octets");

  AST_ZERO_SPLIT: assert property ((q.st == DOS_CALC) && (q.snap.frm_pct == DOS_PCT_ZERO)
    && !q.snap.nl_ds |=> q.frm_bad) // see RQ8
    else $error("zero split accepted without no-limit delay");

  AST_BAD_RANGE: assert property ((q.st == DOS_CALC) && (q.snap.est_pct > DOS_PCT_FULL)
    && (q.snap.est_pct != DOS_PCT_SPECIAL) |=> q.est_bad && q.done) // see RQ15
    else $error("estimate split out of range not flagged");

  AST_EST_P0: assert property ((q.st == DOS_CALC) && est_ok && !q.snap.robust |=> // see RQ11
    (q.est_ds.lo == q.est.lo) && (q.est_us.lo == q.est.hi))
    else $error("single latency path 0 differs from budget");

  AST_EST_P1: assert property ((q.st == DOS_CALC) && est_ok && q.snap.robust
    && (q.snap.path0.lo <= est_ds_sh) |=> // see RQ12
    (32'(q.est_ds.hi) + 32'(q.snap.path0.lo) == 32'(q.est.lo)))
    else $error("robust path limit is not budget minus path 0");

  AST_START: assert property ((q.st == DOS_CALC) |=> (q.st == DOS_IDLE) && q.done)
    else $error("calculation did not complete in one cycle");

  AST_BHOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before taken");

endmodule : dos_delay_octet_split

// File: logic/dos_pkg.sv
// Shared constants, register map and types of the delay octet split calculator
package dos_pkg;

  // ---------------------------------------------------------------
  // Register map (byte offsets)
  // ---------------------------------------------------------------
  localparam int unsigned DOS_ADDR_W   = 6;
  localparam logic [5:0]  DOS_OFS_CTRL   = 6'h00;
  localparam logic [5:0]  DOS_OFS_BUDGET = 6'h04;
  localparam logic [5:0]  DOS_OFS_SPLIT  = 6'h08;
  localparam logic [5:0]  DOS_OFS_RATIO  = 6'h0C;
  localparam logic [5:0]  DOS_OFS_PATH0  = 6'h10;
  localparam logic [5:0]  DOS_OFS_STATUS = 6'h14;
  localparam logic [5:0]  DOS_OFS_FRM    = 6'h18;
  localparam logic [5:0]  DOS_OFS_FRM_DS = 6'h1C;
  localparam logic [5:0]  DOS_OFS_FRM_US = 6'h20;
  localparam logic [5:0]  DOS_OFS_EST    = 6'h24;
  localparam logic [5:0]  DOS_OFS_EST_DS = 6'h28;
  localparam logic [5:0]  DOS_OFS_EST_US = 6'h2C;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned DOS_CTRL_START = 0;
  localparam int unsigned DOS_CTRL_DUAL  = 1;
  localparam int unsigned DOS_CTRL_ROBUST = 2;
  localparam int unsigned DOS_SPLIT_FRM  = 0;
  localparam int unsigned DOS_SPLIT_EST  = 8;
  localparam int unsigned DOS_SPLIT_NLDS = 16;
  localparam int unsigned DOS_SPLIT_NLUS = 17;

  // ---------------------------------------------------------------
  // Percent encodings, reset values and response codes
  // ---------------------------------------------------------------
  localparam logic [7:0]  DOS_PCT_ZERO    = 8'h00;
  localparam logic [7:0]  DOS_PCT_MIN     = 8'h05;
  localparam logic [7:0]  DOS_PCT_MAX     = 8'h5F;
  localparam logic [7:0]  DOS_PCT_FULL    = 8'h64;
  localparam logic [7:0]  DOS_PCT_SPECIAL = 8'hFF;
  localparam logic [7:0]  DOS_PCT_DEF_SPC = 8'h32;
  localparam logic [7:0]  DOS_PCT_RST     = 8'h32;
  localparam logic [15:0] DOS_BUDGET_RST  = 16'h0000;
  localparam logic [1:0]  DOS_RESP_OKAY   = 2'b00;
  localparam logic [1:0]  DOS_RESP_DECERR = 2'b11;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic {DOS_IDLE, DOS_CALC} dos_state_t;

  typedef struct packed {
    logic [15:0] hi;
    logic [15:0] lo;
  } dos_pair_t;

  typedef struct packed {
    logic        dual;
    logic        robust;
    logic [15:0] budget;
    logic [7:0]  frm_pct;
    logic [7:0]  est_pct;
    logic        nl_ds;
    logic        nl_us;
    logic [7:0]  ratio;
    dos_pair_t   path0;
  } dos_cfg_t;

endpackage : dos_pkg

// File: logic/dos_split_calc.sv
// Percentage split of an octet budget with upward rounding and remainder
`timescale 1ns/1ps
module dos_split_calc
  import dos_pkg::*;
#(
  parameter int unsigned W         = 16,
  parameter logic [7:0]  SPEC_PCT  = DOS_PCT_DEF_SPC
) (
  input  wire logic [7:0]   pct,
  input  wire logic [W-1:0] budget,
  input  wire logic         nl_ds,
  input  wire logic         nl_us,
  output logic      [W-1:0] share,
  output logic      [W-1:0] rest,
  output logic              ok,
  output logic              special
);

  logic [7:0]   eff_pct;
  logic [W+7:0] num;

  assign special = (pct == DOS_PCT_SPECIAL);
  // Special value: fixed even share instead of the configured one  see RQ9
  assign eff_pct = special ? SPEC_PCT : ((pct > DOS_PCT_FULL) ? DOS_PCT_FULL : pct);
  // Ceiling of pct * budget / 100 in integers  see RQ1 see RQ15
  assign num   = (W+8)'(eff_pct) * (W+8)'(budget) + (W+8)'(DOS_PCT_FULL - 8'h01);
  assign share = W'(num / (W+8)'(DOS_PCT_FULL));
  assign rest  = budget - share; // see RQ2
  // 0% and 100% only with the no-limit delay in that direction  see RQ8 see RQ15
  assign ok = special
            || ((pct >= DOS_PCT_MIN) && (pct <= DOS_PCT_MAX))
            || ((pct == DOS_PCT_ZERO) && nl_ds)
            || ((pct == DOS_PCT_FULL) && nl_us);

endmodule : dos_split_calc
